/* File: rtl/wtd_sequencer.sv */
// Low-power state and wake-up sequencer with tag detection
`timescale 1ns/1ps
`include "wtd_regs.svh"

// How it works
// - Low power: fast oscillator off except in settle and burst, slow ticks
// - Reference is 256 slow periods, rate bits 7:6
// - Enabled wake and select pin bits wake the device, outside hibernate
// - Power-up waits wake pulse, then 6 ms
// - Hibernate leaves only on wake pin pulse
// - Sleep wakes on wake or select pin
// - Timeout after 256*(gap+2)*(maxsleep+1) periods
// - Source bit 0 enables the timeout
// - Bursts only while tag bit is set
// - Timer bit limits bursts to maxsleep+1
// - Gap of (gap+2) references between bursts
// - Oscillator then converter settle before burst
// - Burst lasts the programmed carrier cycles
// - Converter result stored every burst
// - Out-of-bounds result wakes with tag cause
// - Wake control selects the powered resources
// - Wake cause recorded: 0x01 timeout, 0x02 tag
module wtd_sequencer #(
  parameter int SLOW_DIV = `WTD_SLOW_PERIOD_NS / `WTD_CLK_PERIOD_NS,
  parameter int STARTUP_CYC = `WTD_STARTUP_TIME_US * 1000 / `WTD_CLK_PERIOD_NS
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic srst, // Synchronous reset
  input wire logic wakePinN, // External wake pin, async
  input wire logic spiSelN, // SPI slave select pin, async
  input wire logic cmdFrame, // High while a command frame lasts
  input wire logic cmdValid, // Command byte strobe
  input wire wtd_pkg::wtd_byte_t cmdByte, // Command byte
  input wire logic carrierToggle, // Toggles once per carrier cycle
  input wire logic [5:0] dacValue, // Converter output, async
  output logic readyOut_q, // Ready, commands accepted
  output logic fastOscEn_q, // Fast oscillator enable
  output logic slowOscEn_q, // Slow oscillator enable
  output logic rfBurst_q, // Detection burst active
  output logic wakeEvent_q, // Pulse on return to ready
  output wtd_pkg::wtd_byte_t wakeSource_q, // Wake source select
  output logic [15:0] wakeControl_q, // Wake control field
  output wtd_pkg::wtd_byte_t wakeCause_q, // Last wake cause
  output logic [5:0] dacData_q // Converter data register
);
  import wtd_pkg::*;

  wtd_state_e state_q;
  wtd_state_e state_d;
  wtd_byte_t paramQ [`WTD_NUM_PARAMS];
  logic [3:0] byteIdx_q;
  logic frameBad_q;
  logic cmdDone;
  logic [1:0] wakeSync_q;
  logic [1:0] selSync_q;
  logic [1:0] carSync_q;
  logic [5:0] dacS1_q;
  logic [5:0] dacS2_q;
  logic wakePrev_q;
  logic selPrev_q;
  logic carPrev_q;
  logic wakeRise;
  logic selRise;
  logic carEdge;
  logic [31:0] startCnt_q;
  logic [15:0] divCnt_q;
  logic [15:0] divLimit;
  logic slowTick;
  logic [7:0] refCnt_q;
  logic refWrap;
  logic [8:0] gapCnt_q;
  logic [8:0] gapLast;
  logic gapEnd;
  logic [4:0] trialCnt_q;
  logic [8:0] settleCnt_q;
  logic [8:0] settleTarget;
  logic [7:0] carrierCnt_q;
  logic burstDone;
  logic [7:0] measured;
  logic outOfBounds;
  logic lastTrial;
  logic pinWake;
  logic lowPower;
  logic tagMode;
  wtd_byte_t burst_gap_coefficient;
  wtd_byte_t osc_settle_count;
  wtd_byte_t dac_settle_count;
  wtd_byte_t detect_lower_bound;
  wtd_byte_t detect_upper_bound;
  wtd_byte_t burst_cycle_count;
  logic [4:0] maxSleep;

  function automatic logic isLowPower(input wtd_state_e s);
    isLowPower = (s == ST_HIBER) || (s == ST_SLEEP) || (s == ST_TAG_GAP) ||
                 (s == ST_TAG_SETTLE) || (s == ST_TAG_BURST);
  endfunction : isLowPower

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeSync_q <= 2'b11;
      selSync_q <= 2'b11;
      carSync_q <= 2'b00;
      wakePrev_q <= 1'b1;
      selPrev_q <= 1'b1;
      carPrev_q <= 1'b0;
    end else begin
      wakeSync_q <= {wakeSync_q[0], wakePinN};
      selSync_q <= {selSync_q[0], spiSelN};
      carSync_q <= {carSync_q[0], carrierToggle};
      wakePrev_q <= wakeSync_q[1];
      selPrev_q <= selSync_q[1];
      carPrev_q <= carSync_q[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dacS1_q <= 6'h00;
      dacS2_q <= 6'h00;
    end else begin
      dacS1_q <= dacValue;
      dacS2_q <= dacS1_q;
    end
  end

  // End of a low pulse on either pin
  assign wakeRise = wakeSync_q[1] & ~wakePrev_q;
  assign selRise = selSync_q[1] & ~selPrev_q;
  assign carEdge = carSync_q[1] ^ carPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle command intake

  assign cmdDone = (state_q == ST_READY) && cmdFrame && cmdValid && !frameBad_q &&
                   (byteIdx_q == `WTD_POS_LAST);

  always_ff @(posedge mclk) begin
    if (srst || !cmdFrame) begin
      byteIdx_q <= 4'h0;
      frameBad_q <= 1'b0;
    end else if (cmdValid && state_q == ST_READY && !frameBad_q) begin
      byteIdx_q <= byteIdx_q + 4'h1;
      if ((byteIdx_q == 4'h0 && cmdByte != `WTD_IDLE_CODE) ||
          (byteIdx_q == `WTD_POS_LEN && cmdByte != `WTD_IDLE_LEN) ||
          byteIdx_q == `WTD_POS_LAST) begin
        frameBad_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < `WTD_NUM_PARAMS; i++) begin
        paramQ[i] <= 8'h00;
      end
    end else if (cmdValid && cmdFrame && state_q == ST_READY && !frameBad_q &&
                 byteIdx_q >= `WTD_POS_FIRST_PARAM) begin
      paramQ[byteIdx_q - `WTD_POS_FIRST_PARAM] <= cmdByte;
    end
  end

  // Source and control applied on receipt
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeSource_q <= `WTD_SRC_RESET;
      wakeControl_q <= `WTD_WCTRL_RESET;
    end else if (cmdDone) begin
      wakeSource_q <= paramQ[`WTD_PAR_SOURCE];
      wakeControl_q <= {paramQ[`WTD_PAR_WCTRL_A], paramQ[`WTD_PAR_WCTRL_B]};
    end
  end

  assign burst_gap_coefficient = paramQ[`WTD_PAR_GAP];
  assign osc_settle_count = paramQ[`WTD_PAR_OSC];
  assign dac_settle_count = paramQ[`WTD_PAR_DAC];
  assign detect_lower_bound = paramQ[`WTD_PAR_LOWER];
  assign detect_upper_bound = paramQ[`WTD_PAR_UPPER];
  assign burst_cycle_count = paramQ[`WTD_PAR_SWINGS];
  // Max sleep lives in the five low bits
  assign maxSleep = paramQ[`WTD_PAR_MAXSLEEP][4:0];

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator timebase

  assign lowPower = isLowPower(state_q);
  // Rate bits scale the slow period by 1, 2, 4 or 8
  assign divLimit = 16'(SLOW_DIV) <<
                    {wakeSource_q[`WTD_SRC_RATE_HI], wakeSource_q[`WTD_SRC_RATE_LO]};
  assign slowTick = lowPower && (divCnt_q == divLimit - 16'h1);
  assign refWrap = slowTick && (refCnt_q == `WTD_REF_LAST);
  assign gapLast = {1'b0, burst_gap_coefficient} + 9'h1;
  assign gapEnd = refWrap && (gapCnt_q == gapLast);

  // Low-power timing uses slow ticks, except burst length in carrier edges
  always_ff @(posedge mclk) begin
    if (srst || !lowPower || slowTick) begin
      divCnt_q <= 16'h0;
    end else begin
      divCnt_q <= divCnt_q + 16'h1;
    end
  end

  // Reference of 256 slow periods, restarted per gap
  always_ff @(posedge mclk) begin
    if (srst || (state_q != ST_SLEEP && state_q != ST_TAG_GAP)) begin
      refCnt_q <= 8'h00;
    end else if (slowTick) begin
      refCnt_q <= refCnt_q + 8'h01;
    end
  end

  // Gap counts (gap + 2) references
  always_ff @(posedge mclk) begin
    if (srst || (state_q != ST_SLEEP && state_q != ST_TAG_GAP) || gapEnd) begin
      gapCnt_q <= 9'h000;
    end else if (refWrap) begin
      gapCnt_q <= gapCnt_q + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst settling, carrier count and measurement

  assign settleTarget = {1'b0, osc_settle_count} + {1'b0, dac_settle_count};
  assign measured = {dacS2_q, 2'b00};
  assign burstDone = (state_q == ST_TAG_BURST) && (carrierCnt_q >= burst_cycle_count);
  // Outside the bounds means a tag
  assign outOfBounds = (measured > detect_upper_bound) || (measured < detect_lower_bound);
  assign lastTrial = trialCnt_q == maxSleep;

  always_ff @(posedge mclk) begin
    if (srst || state_q != ST_TAG_SETTLE) begin
      settleCnt_q <= 9'h000;
    end else if (slowTick) begin
      settleCnt_q <= settleCnt_q + 9'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || state_q != ST_TAG_BURST) begin
      carrierCnt_q <= 8'h00;
    end else if (carEdge) begin
      carrierCnt_q <= carrierCnt_q + 8'h01;
    end
  end

  // Converter result captured at burst end
  always_ff @(posedge mclk) begin
    if (srst) begin
      dacData_q <= 6'h00;
    end else if (burstDone) begin
      dacData_q <= dacS2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !lowPower) begin
      trialCnt_q <= 5'h00;
    end else if ((state_q == ST_SLEEP && gapEnd) || (burstDone && !outOfBounds)) begin
      trialCnt_q <= trialCnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state sequencing

  // Enabled pin sources wake the device
  assign pinWake = (wakeRise && wakeSource_q[`WTD_SRC_WAKEPIN]) ||
                   (selRise && wakeSource_q[`WTD_SRC_SELPIN]);
  // Tag detection needs the tag bit
  assign tagMode = paramQ[`WTD_PAR_SOURCE][`WTD_SRC_TAG] &&
                   ({paramQ[`WTD_PAR_WCTRL_A], paramQ[`WTD_PAR_WCTRL_B]} == `WTD_WCTRL_TAG ||
                    {paramQ[`WTD_PAR_WCTRL_A], paramQ[`WTD_PAR_WCTRL_B]} == `WTD_WCTRL_CALIB);

  always_ff @(posedge mclk) begin
    if (srst || state_q != ST_STARTUP) begin
      startCnt_q <= 32'h0;
    end else begin
      startCnt_q <= startCnt_q + 32'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Wait for wake pulse, then startup delay
      ST_POWERUP: if (wakeRise) state_d = ST_STARTUP;
      ST_STARTUP: if (startCnt_q == 32'(STARTUP_CYC - 1)) state_d = ST_READY;
      // Wake control picks the low-power state
      ST_READY: begin
        if (cmdDone) begin
          if ({paramQ[`WTD_PAR_WCTRL_A], paramQ[`WTD_PAR_WCTRL_B]} == `WTD_WCTRL_HIBER) begin
            state_d = ST_HIBER;
          end else if (tagMode) begin
            state_d = ST_TAG_GAP;
          end else begin
            state_d = ST_SLEEP;
          end
        end
      end
      // Only the wake pin leaves hibernate
      ST_HIBER: if (wakeRise) state_d = ST_READY;
      ST_SLEEP: begin
        if (pinWake || (gapEnd && wakeSource_q[`WTD_SRC_TIMER] && lastTrial)) begin
          state_d = ST_READY;
        end
      end
      ST_TAG_GAP: begin
        if (pinWake) state_d = ST_READY;
        else if (gapEnd) state_d = ST_TAG_SETTLE;
      end
      ST_TAG_SETTLE: begin
        if (pinWake) state_d = ST_READY;
        else if (settleCnt_q >= settleTarget) state_d = ST_TAG_BURST;
      end
      // Timer bit bounds the number of bursts
      ST_TAG_BURST: begin
        if (pinWake) begin
          state_d = ST_READY;
        end else if (burstDone) begin
          if (outOfBounds || (wakeSource_q[`WTD_SRC_TIMER] && lastTrial)) begin
            state_d = ST_READY;
          end else begin
            state_d = ST_TAG_GAP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  // Wake cause recorded on return to ready
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeCause_q <= `WTD_CAUSE_NONE;
      wakeEvent_q <= 1'b0;
    end else begin
      wakeEvent_q <= lowPower && state_d == ST_READY;
      if (lowPower && state_d == ST_READY) begin
        if (state_q == ST_HIBER) wakeCause_q <= `WTD_CAUSE_NONE;
        else if (wakeRise && wakeSource_q[`WTD_SRC_WAKEPIN]) wakeCause_q <= `WTD_CAUSE_WAKEPIN;
        else if (pinWake) wakeCause_q <= `WTD_CAUSE_SELPIN;
        else if (burstDone && outOfBounds) wakeCause_q <= `WTD_CAUSE_TAG;
        else wakeCause_q <= `WTD_CAUSE_TIMEOUT;
      end
    end
  end

  // Fast oscillator only for startup, ready, burst settling and bursts
  always_ff @(posedge mclk) begin
    if (srst) begin
      readyOut_q <= 1'b0;
      fastOscEn_q <= 1'b0;
      slowOscEn_q <= 1'b0;
      rfBurst_q <= 1'b0;
    end else begin
      readyOut_q <= state_d == ST_READY;
      fastOscEn_q <= !isLowPower(state_d) && state_d != ST_POWERUP ||
                     state_d == ST_TAG_SETTLE || state_d == ST_TAG_BURST;
      slowOscEn_q <= isLowPower(state_d) && state_d != ST_HIBER;
      rfBurst_q <= state_d == ST_TAG_BURST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_powerup_hold: assert property (
    state_q == ST_POWERUP && !wakeRise |=> state_q == ST_POWERUP && !readyOut_q)
    else $error("left power-up without a wake pulse");
  chk_startup_ready: assert property (
    state_q == ST_STARTUP |-> !readyOut_q && startCnt_q < 32'(STARTUP_CYC))
    else $error("ready before startup delay");
  chk_hiber_stay: assert property (
    state_q == ST_HIBER && !wakeRise |=> state_q == ST_HIBER)
    else $error("hibernate left without wake pin");
  chk_fast_osc_off: assert property (
    (state_q == ST_SLEEP || state_q == ST_TAG_GAP || state_q == ST_HIBER) |-> !fastOscEn_q)
    else $error("fast oscillator running in low power");
  chk_burst_tag_bit: assert property (
    rfBurst_q |-> wakeSource_q[`WTD_SRC_TAG])
    else $error("burst without tag source");
  chk_tag_cause: assert property (
    burstDone && outOfBounds && !pinWake |=> state_q == ST_READY && wakeCause_q == `WTD_CAUSE_TAG
    ##1 readyOut_q)
    else $error("tag detection not reported");
  chk_slow_divider: assert property (
    lowPower && $past(lowPower) && !slowTick && $past(slowTick) |-> divCnt_q == 16'h0)
    else $error("slow divider did not restart");
  chk_sleep_select: assert property (
    state_q == ST_SLEEP && selRise && wakeSource_q[`WTD_SRC_SELPIN] |=> state_q == ST_READY)
    else $error("select pin did not wake sleep");
  chk_gap_end: assert property (
    state_q == ST_TAG_GAP && gapEnd && !pinWake |=> state_q == ST_TAG_SETTLE)
    else $error("gap end did not start settling");
  chk_idle_apply: assert property (
    cmdDone |=> wakeSource_q == $past(paramQ[`WTD_PAR_SOURCE]) ##1 !readyOut_q)
    else $error("idle command not applied");

endmodule : wtd_sequencer

/* File: rtl/wtd_regs.svh */
// Wake-up sequencer constants: idle command layout, codes and timing
`ifndef WTD_REGS_SVH
`define WTD_REGS_SVH

// Idle command framing, byte positions counted from 0 at the code byte
`define WTD_IDLE_CODE 8'h07
`define WTD_IDLE_LEN 8'h0e
`define WTD_POS_LEN 4'h1
`define WTD_POS_FIRST_PARAM 4'h2
`define WTD_POS_LAST 4'hf
`define WTD_NUM_PARAMS 14

// Parameter indices, relative to the first parameter byte
`define WTD_PAR_SOURCE 0
`define WTD_PAR_WCTRL_A 3
`define WTD_PAR_WCTRL_B 4
`define WTD_PAR_GAP 7
`define WTD_PAR_OSC 8
`define WTD_PAR_DAC 9
`define WTD_PAR_LOWER 10
`define WTD_PAR_UPPER 11
`define WTD_PAR_SWINGS 12
`define WTD_PAR_MAXSLEEP 13

// Wake source select bit positions
`define WTD_SRC_TIMER 0
`define WTD_SRC_TAG 1
`define WTD_SRC_WAKEPIN 3
`define WTD_SRC_SELPIN 4
`define WTD_SRC_RATE_HI 7
`define WTD_SRC_RATE_LO 6
`define WTD_SRC_RESET 8'h00

// Wake control values
`define WTD_WCTRL_HIBER 16'h0400
`define WTD_WCTRL_SLEEP 16'h3800
`define WTD_WCTRL_CALIB 16'hf801
`define WTD_WCTRL_TAG 16'h7901
`define WTD_WCTRL_RESET 16'h0000

// Wake cause codes
`define WTD_CAUSE_NONE 8'h00
`define WTD_CAUSE_TIMEOUT 8'h01
`define WTD_CAUSE_TAG 8'h02
`define WTD_CAUSE_WAKEPIN 8'h08
`define WTD_CAUSE_SELPIN 8'h10

// Timing
`define WTD_CLK_PERIOD_NS 50
`define WTD_SLOW_PERIOD_NS 31250
`define WTD_STARTUP_TIME_US 6000
`define WTD_REF_TICKS 256
`define WTD_REF_LAST 8'hff

`endif

/* File: rtl/wtd_pkg.sv */
// Types shared by the wake-up sequencer
package wtd_pkg;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_STARTUP = 3'b001,
    ST_READY = 3'b011,
    ST_HIBER = 3'b010,
    ST_SLEEP = 3'b110,
    ST_TAG_GAP = 3'b111,
    ST_TAG_SETTLE = 3'b101,
    ST_TAG_BURST = 3'b100
  } wtd_state_e;

  typedef logic [7:0] wtd_byte_t;

endpackage : wtd_pkg

/* File: verif/wtd_host_model.sv */
// Host controller model: wake pins and idle command frames
`timescale 1ns/1ps
module wtd_host_model #(
  parameter logic [7:0] GAP = 8'h00,
  parameter logic [7:0] SETTLE = 8'h02,
  parameter logic [7:0] SWINGS = 8'h04,
  parameter logic [7:0] MAX_SLEEP = 8'h01
) (
  input wire logic mclk, // Device clock
  input wire logic readyOut, // Device ready
  output logic wakePinN, // Wake pin
  output logic spiSelN, // Select pin
  output logic cmdFrame, // Frame level
  output logic cmdValid, // Byte strobe
  output wtd_pkg::wtd_byte_t cmdByte // Command byte
);
  import wtd_pkg::*;
  initial begin
    wakePinN = 1'b1;
    spiSelN = 1'b1;
    cmdFrame = 1'b0;
    cmdValid = 1'b0;
    cmdByte = 8'h00;
  end
  task automatic pulse(input logic selPin, input int lowCyc);
    @(negedge mclk);
    if (selPin) begin
      spiSelN = 1'b0;
    end else begin
      wakePinN = 1'b0;
    end
    repeat (lowCyc) @(negedge mclk);
    spiSelN = 1'b1;
    wakePinN = 1'b1;
  endtask : pulse
  // frame order, max sleep in range
  task automatic send_idle(input wtd_byte_t src, input logic [15:0] ctrl,
      input wtd_byte_t lower = 8'h60, input wtd_byte_t upper = 8'h70,
      input wtd_byte_t code = 8'h07);
    wtd_byte_t f [16];
    f = '{code, 8'h0e, src, 8'h21, 8'h00, ctrl[15:8], ctrl[7:0], 8'h18, 8'h00, GAP,
      SETTLE, SETTLE, lower, upper, SWINGS, MAX_SLEEP};
    while (readyOut !== 1'b1) @(negedge mclk);
    for (int i = 0; i < 16; i++) begin
      @(negedge mclk);
      cmdFrame = 1'b1;
      cmdValid = 1'b1;
      cmdByte = f[i];
    end
    @(negedge mclk);
    cmdFrame = 1'b0;
    cmdValid = 1'b0;
    // Released lines show no stale byte
    cmdByte = ~cmdByte;
  endtask : send_idle
endmodule : wtd_host_model

/* File: verif/testbench.sv */
// Self-checking bench for the wake-up sequencer
`timescale 1ns/1ps
module testbench;
  import wtd_pkg::*;
  localparam int SLOW_DIV = 2;
  localparam int STARTUP_CYC = 20;
  localparam int GAP = 0;
  localparam int SETTLE = 2;
  localparam int SWINGS = 4;
  localparam int MAX_SLEEP = 1;
  localparam int PERIOD = 256 * (GAP + 2) * SLOW_DIV;
  localparam int LIMIT = 80000;
  logic mclk, srst, wakePinN, spiSelN, cmdFrame, cmdValid;
  logic carrierToggle = 1'b0;
  logic carrierDiv = 1'b0;
  logic burstPrev = 1'b0;
  wtd_byte_t cmdByte, wakeSource_q, wakeCause_q;
  logic [5:0] dacValue, dacData_q;
  logic readyOut_q, fastOscEn_q, slowOscEn_q, rfBurst_q, wakeEvent_q;
  logic [15:0] wakeControl_q;
  int nFail = 0;
  int totalChecks = 0;
  int cycles = 0;
  int nBursts = 0;
  int burstLen = 0;
  int burstGap = 0;
  int sinceStart = 0;
  int n, t;

  wtd_sequencer #(.SLOW_DIV(SLOW_DIV), .STARTUP_CYC(STARTUP_CYC)) i_dut (
    .mclk(mclk), .srst(srst), .wakePinN(wakePinN), .spiSelN(spiSelN),
    .cmdFrame(cmdFrame), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .carrierToggle(carrierToggle), .dacValue(dacValue), .readyOut_q(readyOut_q),
    .fastOscEn_q(fastOscEn_q), .slowOscEn_q(slowOscEn_q), .rfBurst_q(rfBurst_q),
    .wakeEvent_q(wakeEvent_q), .wakeSource_q(wakeSource_q),
    .wakeControl_q(wakeControl_q), .wakeCause_q(wakeCause_q), .dacData_q(dacData_q));

  wtd_host_model #(.GAP(8'(GAP)), .SETTLE(8'(SETTLE)), .SWINGS(8'(SWINGS)),
    .MAX_SLEEP(8'(MAX_SLEEP))) i_host (
    .mclk(mclk), .readyOut(readyOut_q), .wakePinN(wakePinN), .spiSelN(spiSelN),
    .cmdFrame(cmdFrame), .cmdValid(cmdValid), .cmdByte(cmdByte));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier every two clocks, burst monitor, cycle limit
  always @(negedge mclk) begin
    carrierDiv <= ~carrierDiv;
    if (carrierDiv) carrierToggle <= ~carrierToggle;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    sinceStart <= sinceStart + 1;
    burstPrev <= rfBurst_q;
    if (rfBurst_q === 1'b1 && burstPrev !== 1'b1) begin
      nBursts <= nBursts + 1;
      burstGap <= sinceStart;
      sinceStart <= 1;
      burstLen <= 1;
    end else if (rfBurst_q === 1'b1) begin
      burstLen <= burstLen + 1;
    end
    if (cycles == LIMIT) begin
      $display("mismatch cycle limit expected %0d seen %0d", LIMIT - 1, cycles);
      nFail++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    totalChecks++;
    if (got < lo || got > hi) begin
      nFail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range
  task automatic wait_ready(input logic ev, output int cnt);
    cnt = 0;
    while (readyOut_q !== 1'b1 && cnt < 40000) begin
      @(negedge mclk);
      cnt++;
    end
    if (ev) check("wake event", 16'h1, 16'(wakeEvent_q));
  endtask : wait_ready
  task automatic wait_low();
    repeat (4) @(negedge mclk);
    check("ready dropped", 16'h0, 16'(readyOut_q));
  endtask : wait_low
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    dacValue = 6'h19;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    repeat (30) @(negedge mclk);
    check("ready before wake", 16'h0, 16'(readyOut_q));
    i_host.pulse(1'b0, 3);
    wait_ready(1'b0, n);
    check_range("startup", STARTUP_CYC, STARTUP_CYC + 10, n);
    check("fast osc ready", 16'h1, 16'(fastOscEn_q));
    $display("test startup done");

    i_host.send_idle(8'h08, 16'h0400);
    wait_low();
    check("source", 16'h0008, 16'(wakeSource_q));
    check("control", 16'h0400, wakeControl_q);
    check("fast osc hib", 16'h0, 16'(fastOscEn_q));
    i_host.pulse(1'b1, 3);
    repeat (20) @(negedge mclk);
    check("ready in hib", 16'h0, 16'(readyOut_q));
    i_host.pulse(1'b0, 6);
    wait_ready(1'b1, n);
    check_range("hib wake", 1, 8, n);
    // Cause after hibernate is not meaningful
    i_host.send_idle(8'h01, 16'h3800, 8'h60, 8'h70, 8'h08);
    repeat (20) @(negedge mclk);
    check("ready bad code", 16'h1, 16'(readyOut_q));
    check("source kept", 16'h0008, 16'(wakeSource_q));
    $display("test hibernate done");

    i_host.send_idle(8'h10, 16'h3800);
    wait_low();
    check("control", 16'h3800, wakeControl_q);
    check("fast osc", 16'h0, 16'(fastOscEn_q));
    check("slow osc", 16'h1, 16'(slowOscEn_q));
    i_host.pulse(1'b0, 3);
    repeat (20) @(negedge mclk);
    check("disabled pin", 16'h0, 16'(readyOut_q));
    i_host.pulse(1'b1, 6);
    wait_ready(1'b1, n);
    check_range("select wake", 1, 8, n);
    check("cause sel", 16'h0010, 16'(wakeCause_q));
    $display("test sleep done");

    for (int r = 0; r < 4; r++) begin
      i_host.send_idle({r[1:0], 6'h01}, 16'h3800);
      t = PERIOD * (MAX_SLEEP + 1) * (1 << r);
      wait_ready(1'b1, n);
      check_range("timeout", t - t / 16, t + t / 16, n);
      check("cause timeout", 16'h0001, 16'(wakeCause_q));
    end
    check_range("no bursts", 0, 0, nBursts);
    $display("test timer done");

    t = nBursts;
    i_host.send_idle(8'h03, 16'h7901);
    wait_ready(1'b1, n);
    check_range("timed bursts", t + MAX_SLEEP + 1, t + MAX_SLEEP + 1, nBursts);
    check("cause in bounds", 16'h0001, 16'(wakeCause_q));
    check("dac data", 16'h0019, 16'(dacData_q));
    check_range("burst len", 2 * SWINGS, 2 * SWINGS + 6, burstLen);
    check_range("burst gap", PERIOD + 2 * SETTLE * SLOW_DIV, PERIOD + 40, burstGap);
    t = nBursts;
    i_host.send_idle(8'h0a, 16'h7901);
    n = 0;
    while (nBursts < t + 3 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check_range("endless bursts", t + 3, t + 3, nBursts);
    i_host.pulse(1'b0, 3);
    wait_ready(1'b1, n);
    check("cause pin", 16'h0008, 16'(wakeCause_q));
    for (int k = 0; k < 2; k++) begin
      dacValue = (k == 0) ? 6'h30 : 6'h04;
      t = nBursts;
      i_host.send_idle(8'h0a, 16'h7901);
      wait_ready(1'b1, n);
      check("cause tag", 16'h0002, 16'(wakeCause_q));
      check_range("tag bursts", t + 1, t + 1, nBursts);
      check("dac out", 16'(dacValue), 16'(dacData_q));
    end
    $display("test tag done");

    // Upper bound stepped down, lower forced to zero, until cause turns to tag
    dacValue = 6'h19;
    t = 0;
    for (int u = 8'h66; u >= 8'h63 && t == 0; u--) begin
      i_host.send_idle(8'h03, 16'hf801, 8'h00, 8'(u));
      wait_ready(1'b1, n);
      if (wakeCause_q == 8'h02) t = u;
    end
    check("calib reference", 16'h0063, 16'(t));
    i_host.send_idle(8'h0b, 16'h7901, 8'(t - 8), 8'(t + 8));
    wait_ready(1'b1, n);
    check("cause guarded", 16'h0001, 16'(wakeCause_q));
    $display("test calibration done");
    report_and_stop();
  end
endmodule : testbench
